// ===== design/benc_top.sv
// bulk endpoint nak control with two-bank fifos and wishbone registers
`timescale 1ns/1ps
`include "benc_map.svh"

// Operation
// - The nak control register is an 8-bit unit and bit 0 is read-only.
// - A write to the bulk-out nak bit lands only while its enable is 1.
// - Nak bits of an endpoint unsupported by mapping have no effect.
// - A fifo clear shows in the nak register within five usb clocks.
// - Writes to the bulk-out nak bit are ignored while nak is sent.
// - Bit 0 allows bulk-in data when 1 and forces nak when 0 at reset.
// - The bulk-in bit drops only when the engine bank cannot supply.
// - A bulk-in toggle sets the bit and the bank is kept for retry.
// - Bulk-in banks toggle when the cpu bank is complete and the engine is empty.
// - Filling the cpu bank toggles and sets the bit by itself.
// - The short-packet end bit toggles once the engine bank is empty and then returns to 0.
// - The bulk-out nak write enable passes writes at 1, blocks at 0.
module benc_top (
  input  wire logic                  clk_sys,
  input  wire logic                  reset_n,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [17:0]           wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic                       wb_ack_o,
  output logic [31:0]                wb_dat_o,
  input  wire benc_pkg::benc_sie_ev_t sieEv,
  input  wire benc_pkg::benc_beat_t  rxBeat,
  output logic                       rxReady,
  output benc_pkg::benc_beat_t       txBeat,
  input  wire logic                  txReady,
  output benc_pkg::benc_hs_t         hs
);
  import benc_pkg::*;

  wire        take   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wrTake = take & wb_we_i & wb_sel_i[0];
  wire        rdTake = take & ~wb_we_i;
  wire [15:0] idx    = wb_adr_i[17:2];
  wire [7:0]  wbByte = wb_dat_i[7:0];

  wire hitNak    = idx == `BENC_IDX_NAK;
  wire hitMask   = idx == `BENC_IDX_MASK;
  wire hitDend   = idx == `BENC_IDX_DEND;
  wire hitClr    = idx == `BENC_IDX_CLR;
  wire hitMap    = idx == `BENC_IDX_MAP;
  wire hitInBuf  = idx == `BENC_IDX_INBUF;
  wire hitOutBuf = idx == `BENC_IDX_OUTBUF;
  wire hitStat   = idx == `BENC_IDX_STAT;

  logic       inAllow;
  logic       outNak;
  logic       outNakWen;
  logic       dataEnd;
  logic       mapIn;
  logic       mapOut;
  logic [1:0] clrPend;
  logic [2:0] clrCnt;
  logic [4:0] usbDiv;

  wire usbTick = usbDiv == 5'(`BENC_USB_DIV - 1);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      usbDiv <= 5'h00;
    end else begin
      usbDiv <= usbTick ? 5'h00 : usbDiv + 5'h01;
    end
  end

  wire clrWr   = wrTake & hitClr & (|wbByte[1:0]);
  wire clrFire = (|clrPend) & usbTick &
                 (clrCnt == 3'(`BENC_CLR_USB_CLKS - 1));
  wire clrIn   = clrFire & clrPend[`BENC_CLR_IN_BIT];
  wire clrOut  = clrFire & clrPend[`BENC_CLR_OUT_BIT];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      clrPend <= 2'h0;
      clrCnt  <= 3'h0;
    end else if (clrWr) begin
      // a new clear restarts the wait so nothing is merged half-done
      clrPend <= wbByte[1:0];
      clrCnt  <= 3'h0;
    end else if (clrFire) begin
      clrPend <= 2'h0;
      clrCnt  <= 3'h0;
    end else if ((|clrPend) & usbTick) begin
      clrCnt  <= clrCnt + 3'h1;
    end
  end

  wire inMapped  = mapIn & sieEv.ifaceActive;
  wire outMapped = mapOut & sieEv.ifaceActive;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      {mapOut, mapIn} <= `BENC_MAP_RST;
      outNakWen       <= `BENC_MASK_RST;
    end else begin
      if (wrTake & hitMap) begin
        mapIn  <= wbByte[`BENC_MAP_IN_BIT];
        mapOut <= wbByte[`BENC_MAP_OUT_BIT];
      end
      if (wrTake & hitMask) begin
        outNakWen <= wbByte[`BENC_MASK_OUT_BIT];
      end
    end
  end

  logic [7:0] inMem [0:127];
  logic       cpuInBank;
  logic [6:0] cpuInCnt;
  logic [6:0] sieInCnt;
  logic [6:0] sendPtr;

  wire cpuInFull = cpuInCnt == `BENC_BANK_BYTES;
  wire inBufWr   = wrTake & hitInBuf & ~cpuInFull & ~dataEnd;
  wire cpuInDone = cpuInFull | dataEnd;
  wire inToggle  = cpuInDone & ~inAllow &
                   (sieInCnt == 7'h00) & ~clrIn;
  wire txLoad    = ~txBeat.valid | txReady;
  wire txPush    = inAllow & inMapped & (sendPtr < sieInCnt) & txLoad &
                   ~sieEv.inAck & ~sieEv.inRetry;
  wire [7:0] txByte = inMem[{~cpuInBank, sendPtr[5:0]}];

  always_ff @(posedge clk_sys) begin
    if (inBufWr) begin
      inMem[{cpuInBank, cpuInCnt[5:0]}] <= wbByte;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cpuInBank <= 1'b0;
      cpuInCnt  <= 7'h00;
      sieInCnt  <= 7'h00;
      sendPtr   <= 7'h00;
    end else if (clrIn) begin
      cpuInCnt  <= 7'h00;
      sieInCnt  <= 7'h00;
      sendPtr   <= 7'h00;
    end else if (inToggle) begin
      cpuInBank <= ~cpuInBank;
      sieInCnt  <= cpuInCnt;
      cpuInCnt  <= 7'h00;
      sendPtr   <= 7'h00;
    end else begin
      if (inBufWr) begin
        cpuInCnt <= cpuInCnt + 7'h01;
      end
      if (sieEv.inAck & inAllow) begin
        sieInCnt <= 7'h00;
        sendPtr  <= 7'h00;
      end else if (sieEv.inRetry) begin
        sendPtr  <= 7'h00;
      end else if (txPush) begin
        sendPtr  <= sendPtr + 7'h01;
      end
    end
  end

  // handshake bit: set by a toggle, dropped once the bank is acknowledged
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      inAllow <= `BENC_NAK_RST;
    end else if (clrIn) begin
      inAllow <= 1'b0;
    end else if (inToggle) begin
      inAllow <= 1'b1;
    end else if (sieEv.inAck) begin
      inAllow <= 1'b0;
    end
  end

  // software set wins over the self-clear in the same cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dataEnd <= 1'b0;
    end else if (wrTake & hitDend & wbByte[`BENC_DEND_BIT]) begin
      dataEnd <= 1'b1;
    end else if (inToggle | clrIn) begin
      dataEnd <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      txBeat <= '0;
    end else if (clrIn | sieEv.inRetry | sieEv.inAck) begin
      txBeat.valid <= 1'b0;
    end else if (txPush) begin
      txBeat <= {1'b1, txByte};
    end else if (txReady) begin
      txBeat.valid <= 1'b0;
    end
  end

  logic [7:0] outMem [0:127];
  logic       cpuOutBank;
  logic [6:0] cpuOutCnt;
  logic [6:0] cpuOutRd;
  logic [6:0] sieOutCnt;
  logic       sieOutHas;
  logic       endPend;
  logic       bufValid;
  logic [7:0] bufData;

  // drain stalls while the engine bank waits, so the buffer backs up
  wire bufReady  = ~sieOutHas & (sieOutCnt != `BENC_BANK_BYTES) & ~clrOut;
  wire bufPop    = bufValid & bufReady;
  wire outFinal  = endPend & ~bufValid & ~sieOutHas & ~clrOut;
  wire cpuOutEmp = cpuOutRd == cpuOutCnt;
  wire outToggle = sieOutHas & cpuOutEmp & ~clrOut;
  wire outBufRd  = rdTake & hitOutBuf & ~cpuOutEmp;
  wire [6:0] outLeft = cpuOutCnt - cpuOutRd;

  benc_buf2 u_rx_buf (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .inBeat   (rxBeat),
    .inReady  (rxReady),
    .outValid (bufValid),
    .outData  (bufData),
    .outReady (bufReady)
  );

  always_ff @(posedge clk_sys) begin
    if (bufPop) begin
      outMem[{~cpuOutBank, sieOutCnt[5:0]}] <= bufData;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      endPend <= 1'b0;
    end else if (clrOut | sieEv.rxBad | outFinal) begin
      endPend <= sieEv.rxEnd & ~sieEv.rxBad;
    end else if (sieEv.rxEnd) begin
      endPend <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cpuOutBank <= 1'b0;
      cpuOutCnt  <= 7'h00;
      cpuOutRd   <= 7'h00;
      sieOutCnt  <= 7'h00;
      sieOutHas  <= 1'b0;
    end else if (clrOut) begin
      cpuOutCnt  <= 7'h00;
      cpuOutRd   <= 7'h00;
      sieOutCnt  <= 7'h00;
      sieOutHas  <= 1'b0;
    end else if (outToggle) begin
      cpuOutBank <= ~cpuOutBank;
      cpuOutCnt  <= sieOutCnt;
      cpuOutRd   <= 7'h00;
      sieOutCnt  <= 7'h00;
      sieOutHas  <= 1'b0;
    end else begin
      if (outBufRd) begin
        cpuOutRd <= cpuOutRd + 7'h01;
      end
      if (sieEv.rxBad) begin
        sieOutCnt <= 7'h00;
      end else if (bufPop) begin
        sieOutCnt <= sieOutCnt + 7'h01;
      end
      if (outFinal) begin
        sieOutHas <= 1'b1;
      end
    end
  end

  // bulk-out nak: hardware set last so it wins over a software clear
  wire nakWrOk = wrTake & hitNak & outNakWen & ~sieEv.nakSending;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      outNak <= `BENC_NAK_RST;
    end else if (clrOut) begin
      outNak <= 1'b0;
    end else begin
      if (outToggle) begin
        outNak <= 1'b0;
      end
      if (nakWrOk) begin
        outNak <= wbByte[`BENC_NAK_OUT_BIT];
      end
      if (outFinal) begin
        outNak <= 1'b1;
      end
    end
  end

  // handshake outputs to the engine; unsupported endpoints show nothing
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hs <= '0;
    end else begin
      hs.inNak  <= inMapped & ~inAllow;
      hs.outNak <= outMapped & outNak;
    end
  end

  wire [7:0] nakVal = {5'h00, outNak, 1'b0, inAllow};
  wire [7:0] mskVal = {5'h00, outNakWen, 2'h0};
  wire [7:0] outVal = outMem[{cpuOutBank, cpuOutRd[5:0]}];
  wire [31:0] rdMux =
    hitNak    ? {24'h000000, nakVal} :
    hitMask   ? {24'h000000, mskVal} :
    hitDend   ? {31'h00000000, dataEnd} :
    hitClr    ? {30'h00000000, clrPend} :
    hitMap    ? {30'h00000000, mapOut, mapIn} :
    hitInBuf  ? {25'h0000000, cpuInCnt} :
    hitOutBuf ? {24'h000000, cpuOutEmp ? 8'h00 : outVal} :
    hitStat   ? {17'h00000, sieInCnt, 1'b0, outLeft} :
                32'h00000000;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= take;
      if (rdTake) begin
        wb_dat_o <= rdMux;
      end
    end
  end

endmodule

// ===== design/benc_map.svh
// register map, bit positions, reset values and timing counts
`ifndef BENC_MAP_SVH
`define BENC_MAP_SVH

// register indices; byte address is four times the index
`define BENC_IDX_NAK       16'hff62
`define BENC_IDX_MASK      16'hff63
`define BENC_IDX_DEND      16'hff70
`define BENC_IDX_CLR       16'hff71
`define BENC_IDX_MAP       16'hff72
`define BENC_IDX_INBUF     16'hff73
`define BENC_IDX_OUTBUF    16'hff74
`define BENC_IDX_STAT      16'hff75

`define BENC_NAK_IN_BIT    0
`define BENC_NAK_OUT_BIT   2
`define BENC_MASK_OUT_BIT  2
`define BENC_DEND_BIT      0
`define BENC_CLR_IN_BIT    0
`define BENC_CLR_OUT_BIT   1
`define BENC_MAP_IN_BIT    0
`define BENC_MAP_OUT_BIT   1

`define BENC_NAK_RST       1'b0
`define BENC_MASK_RST      1'b0
`define BENC_MAP_RST       2'h3

`define BENC_BANK_BYTES    7'h40

// usb clock as a tick from the system clock
`define BENC_SYS_CLK_KHZ   200000
`define BENC_USB_CLK_KHZ   12000
`define BENC_USB_DIV       (`BENC_SYS_CLK_KHZ / `BENC_USB_CLK_KHZ)
`define BENC_CLR_USB_CLKS  4

`endif

// ===== design/benc_pkg.sv
// types shared by the bulk endpoint nak control block
package benc_pkg;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } benc_beat_t;

  typedef struct packed {
    logic inAck;
    logic inRetry;
    logic rxEnd;
    logic rxBad;
    logic nakSending;
    logic ifaceActive;
  } benc_sie_ev_t;

  typedef struct packed {
    logic inNak;
    logic outNak;
  } benc_hs_t;

endpackage

// ===== design/benc_buf2.sv
// two-entry byte buffer with valid and ready on both sides
`timescale 1ns/1ps
module benc_buf2 (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire benc_pkg::benc_beat_t inBeat,
  output logic                   inReady,
  output logic                   outValid,
  output logic [7:0]             outData,
  input  wire logic              outReady
);
  import benc_pkg::*;

  logic [7:0] mem [0:1];
  logic       wrPtr;
  logic       rdPtr;
  logic [1:0] cnt;

  wire        push = inBeat.valid & inReady;
  wire        pop  = outValid & outReady;
  wire [1:0]  next_cnt = cnt + {1'b0, push} - {1'b0, pop};

  assign outValid = cnt != 2'h0;
  assign outData  = mem[rdPtr];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr] <= inBeat.data;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr   <= 1'b0;
      rdPtr   <= 1'b0;
      cnt     <= 2'h0;
      inReady <= 1'b1;
    end else begin
      wrPtr   <= wrPtr ^ push;
      rdPtr   <= rdPtr ^ pop;
      cnt     <= next_cnt;
      // registered ready stays honest: it looks at the next fill level
      inReady <= next_cnt != 2'h2;
    end
  end

endmodule

// ===== dv/benc_top_asserts.sv
// port checks for the bulk endpoint nak control block
`timescale 1ns/1ps
`include "benc_map.svh"
module benc_asserts (
  input wire logic                   clk_sys,
  input wire logic                   reset_n,
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_we_i,
  input wire logic [17:0]            wb_adr_i,
  input wire logic [3:0]             wb_sel_i,
  input wire logic [31:0]            wb_dat_i,
  input wire logic                   wb_ack_o,
  input wire logic [31:0]            wb_dat_o,
  input wire benc_pkg::benc_sie_ev_t sieEv,
  input wire benc_pkg::benc_beat_t   rxBeat,
  input wire logic                   rxReady,
  input wire benc_pkg::benc_beat_t   txBeat,
  input wire logic                   txReady,
  input wire benc_pkg::benc_hs_t     hs
);
  import benc_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire wrTake = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  wire wrNak  = wrTake && wb_adr_i == {`BENC_IDX_NAK, 2'b00};
  wire wrDend = wrTake && wb_adr_i == {`BENC_IDX_DEND, 2'b00};
  wire wrClr  = wrTake && wb_adr_i == {`BENC_IDX_CLR, 2'b00};
  // five usb clocks plus the registered status lag
  localparam int ClrLim = 5 * `BENC_USB_DIV + 2;
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  chk_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  chk_ack_cause: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  chk_tx_hold: assert property (
    txBeat.valid && !txReady && !sieEv.inAck && !sieEv.inRetry
    |=> txBeat.valid && $stable(txBeat.data))
    else $error("bulk-in byte changed while stalled");
  chk_in_allow: assert property ($rose(txBeat.valid) |-> !hs.inNak)
    else $error("bulk-in data sent while nak");
  chk_in_drop: assert property ($rose(hs.inNak) |-> !txBeat.valid)
    else $error("bulk-in nak while data available");
  chk_nak_busy: assert property (
    wrNak && wb_dat_i[2] && sieEv.nakSending && !hs.outNak
    |=> !hs.outNak [*3])
    else $error("bulk-out nak written while nak sent");
  chk_dend_toggle: assert property (
    wrDend && wb_dat_i[0] |-> ##[1:6] !hs.inNak)
    else $error("short packet end gave no toggle");
  chk_clr_status: assert property (
    wrClr && wb_dat_i[1] |-> ##[1:ClrLim] !hs.outNak)
    else $error("fifo clear not shown in time");
endmodule

bind benc_top benc_asserts u_chk (.clk_sys, .reset_n, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .sieEv,
  .rxBeat, .rxReady, .txBeat, .txReady, .hs);

// ===== dv/benc_sie_model.sv
// engine-side partner streaming bulk bytes and bus events
`timescale 1ns/1ps
module benc_sie_model (
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  input  wire benc_pkg::benc_beat_t txBeat,
  output logic                      txReady,
  output benc_pkg::benc_beat_t      rxBeat,
  input  wire logic                 rxReady,
  output benc_pkg::benc_sie_ev_t    sieEv
);
  import benc_pkg::*;
  logic       evAck   = 1'b0;
  logic       evRetry = 1'b0;
  logic       evEnd   = 1'b0;
  logic       evBad   = 1'b0;
  logic       nakLvl  = 1'b0;
  logic       ifcLvl  = 1'b1;
  logic [7:0] got [$];
  assign sieEv = {evAck, evRetry, evEnd, evBad, nakLvl, ifcLvl};
  initial begin
    txReady = 1'b0;
    rxBeat = '0;
  end
  task setNak(input logic v);
    @(posedge clk_sys);
    nakLvl <= v;
  endtask
  task setIface(input logic v);
    @(posedge clk_sys);
    ifcLvl <= v;
  endtask
  // a bad packet ends with an error pulse instead of an end pulse
  task sendOut(input int n, input logic [7:0] base, input logic bad);
    for (int i = 0; i < n; i++) begin
      rxBeat <= '{1'b1, base + 8'(i)};
      do @(posedge clk_sys); while (rxReady !== 1'b1);
    end
    // released data line shows no stale byte
    rxBeat <= '{1'b0, ~rxBeat.data};
    evEnd <= !bad;
    evBad <= bad;
    @(posedge clk_sys);
    evEnd <= 1'b0;
    evBad <= 1'b0;
  endtask
  // stall toggles ready every cycle; retry ends with a resend request
  task takeIn(input int n, input logic stall, input logic retry);
    got.delete();
    while (got.size() < n) begin
      txReady <= stall ? ~txReady : 1'b1;
      @(posedge clk_sys);
      if (txBeat.valid === 1'b1 && txReady === 1'b1)
        got.push_back(txBeat.data);
    end
    txReady <= 1'b0;
    evRetry <= retry;
    evAck <= !retry;
    @(posedge clk_sys);
    evRetry <= 1'b0;
    evAck <= 1'b0;
  endtask
endmodule

// ===== dv/tb_top.sv
// self-checking bench for the bulk endpoint nak control block
`timescale 1ns/1ps
`include "benc_map.svh"
module tb_top;
  import benc_pkg::*;
  logic         clk_sys = 1'b0;
  logic         reset_n = 1'b0;
  logic         wbCyc = 1'b0;
  logic         wbStb = 1'b0;
  logic         wbWe = 1'b0;
  logic         wbAck;
  logic [17:0]  wbAdr = 18'h0;
  logic [3:0]   wbSel = 4'h0;
  logic [31:0]  wbDat = 32'h0;
  logic [31:0]  wbQ;
  logic [31:0]  rdv;
  benc_sie_ev_t sieEv;
  benc_beat_t   rxBeat;
  benc_beat_t   txBeat;
  logic         rxReady;
  logic         txReady;
  benc_hs_t     hs;
  int           n_fail = 0;
  int           cmp_count = 0;
  int           cycleCount = 0;
  always #2.5 clk_sys = ~clk_sys;
  benc_top dut (.clk_sys, .reset_n, .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
    .wb_ack_o(wbAck), .wb_dat_o(wbQ), .sieEv, .rxBeat, .rxReady, .txBeat,
    .txReady, .hs);
  benc_sie_model sie (.clk_sys, .reset_n, .txBeat, .txReady, .rxBeat,
    .rxReady, .sieEv);
  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task wb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    @(posedge clk_sys);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= {idx, 2'b00};
    wbSel <= 4'h1;
    wbDat <= {24'h0, d};
    do @(posedge clk_sys); while (wbAck !== 1'b1);
    rdv = wbQ;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  task rdChk(input string what, input logic [15:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00);
    chk(what, {24'h0, e}, rdv);
  endtask
  // hs sampled mid-cycle, clear of edge updates
  task hsChk(input logic [1:0] e);
    @(negedge clk_sys);
    chk("hs", {30'h0, e}, {30'h0, hs});
  endtask
  task s_reset;
    rdChk("nak", `BENC_IDX_NAK, 8'h00);
    rdChk("mask", `BENC_IDX_MASK, 8'h00);
    rdChk("map", `BENC_IDX_MAP, 8'h03);
    rdChk("unmapped", 16'h0000, 8'h00);
    chk("rxReady", 32'h1, {31'h0, rxReady});
    hsChk(2'b10);
  endtask
  task s_regs;
    wb(1'b1, `BENC_IDX_NAK, 8'h05);
    rdChk("nak", `BENC_IDX_NAK, 8'h00);
    wb(1'b1, `BENC_IDX_MASK, 8'h04);
    wb(1'b1, `BENC_IDX_NAK, 8'h04);
    rdChk("nak", `BENC_IDX_NAK, 8'h04);
    hsChk(2'b11);
    wb(1'b1, `BENC_IDX_MAP, 8'h00);
    hsChk(2'b00);
    wb(1'b1, `BENC_IDX_MAP, 8'h03);
    sie.setIface(1'b0);
    repeat (2) @(posedge clk_sys);
    hsChk(2'b00);
    sie.setIface(1'b1);
    wb(1'b1, `BENC_IDX_NAK, 8'h00);
    sie.setNak(1'b1);
    wb(1'b1, `BENC_IDX_NAK, 8'h04);
    rdChk("nak", `BENC_IDX_NAK, 8'h00);
    sie.setNak(1'b0);
  endtask
  // two full banks: second waits for the engine bank to empty
  task s_in;
    for (int i = 0; i < 128; i++) wb(1'b1, `BENC_IDX_INBUF, 8'(i));
    rdChk("nak", `BENC_IDX_NAK, 8'h01);
    for (int p = 0; p < 2; p++) begin
      sie.takeIn(64, 1'b1, 1'b0);
      for (int i = 0; i < 64; i++)
        chk("txByte", 32'(p * 64 + i), {24'h0, sie.got[i]});
    end
    rdChk("nak", `BENC_IDX_NAK, 8'h00);
    hsChk(2'b10);
  endtask
  task s_short;
    for (int i = 0; i < 3; i++) wb(1'b1, `BENC_IDX_INBUF, 8'ha0 + 8'(i));
    rdChk("nak", `BENC_IDX_NAK, 8'h00);
    wb(1'b1, `BENC_IDX_DEND, 8'h01);
    rdChk("nak", `BENC_IDX_NAK, 8'h01);
    rdChk("dend", `BENC_IDX_DEND, 8'h00);
    sie.takeIn(3, 1'b0, 1'b1);
    sie.takeIn(3, 1'b1, 1'b0);
    for (int i = 0; i < 3; i++)
      chk("retryByte", 32'ha0 + 32'(i), {24'h0, sie.got[i]});
  endtask
  task s_out;
    sie.sendOut(3, 8'h30, 1'b1);
    rdChk("nak", `BENC_IDX_NAK, 8'h00);
    sie.sendOut(5, 8'h00, 1'b0);
    sie.sendOut(5, 8'h10, 1'b0);
    rdChk("nak", `BENC_IDX_NAK, 8'h04);
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, `BENC_IDX_OUTBUF, 8'h00);
      chk("rxByte", 32'(i), rdv);
    end
    rdChk("nak", `BENC_IDX_NAK, 8'h00);
    sie.sendOut(5, 8'h20, 1'b0);
    rdChk("nak", `BENC_IDX_NAK, 8'h04);
    wb(1'b1, `BENC_IDX_CLR, 8'h02);
    repeat (5 * `BENC_USB_DIV) @(posedge clk_sys);
    rdChk("nak", `BENC_IDX_NAK, 8'h00);
  endtask
  task summarize;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycleCount++;
    if (cycleCount == 20000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    s_reset();
    s_regs();
    s_in();
    s_short();
    s_out();
    summarize();
  end
endmodule
